// ===== inc/eil_params.svh
// constants for the external interrupt latch: offsets, fields, resets
`ifndef EIL_PARAMS_SVH
`define EIL_PARAMS_SVH

// apb register byte offsets
`define EIL_OFF_SCR   12'h000
`define EIL_OFF_EVT   12'h004
`define EIL_OFF_EEN   12'h008
`define EIL_OFF_VEC   12'h00C

// status and control field positions
`define EIL_B_MODE    0
`define EIL_B_MASK    1
`define EIL_B_ACK     2
`define EIL_B_PEND    3

// event status / enable field positions
`define EIL_EV_LATCH  0
`define EIL_EV_ACK    1
`define EIL_EV_W      2

// reset values
`define EIL_RST_BIT   1'b0
`define EIL_RST_PIN   1'b1
`define EIL_RST_EV    2'h0
`define EIL_RST_WORD  32'h0000_0000
`define EIL_RST_WARM  2'h0

// clock cycles after reset before the edge detector may trust its history
`define EIL_WARM_DONE 2'h3
`define EIL_WARM_STEP 2'h1

// vector pair fetched for this interrupt
`define EIL_VEC_HI    16'hFFFA
`define EIL_VEC_LO    16'hFFFB

`endif

// ===== inc/eil_pkg.sv
// types shared by the external interrupt latch
`default_nettype none
package eil_pkg;
   // sensitivity selection
   typedef enum logic [1:0] {
      EIL_SENS_EDGE  = 2'b01,
      EIL_SENS_LEVEL = 2'b10
   } eil_sens_e;

   typedef logic [31:0] eil_word_t;
   typedef logic [11:0] eil_addr_t;
   typedef logic [1:0]  eil_ev_t;
endpackage
`default_nettype wire

// ===== hw/eil_top.sv
// external interrupt latch with apb status/control and event registers

`timescale 1ns/1ns
`default_nettype none
`include "eil_params.svh"

module eil_top
   import eil_pkg::*;
(
   input  wire logic        i_clock,              // 10 MHz bus clock
   input  wire logic        i_nrst,               // sync reset, active low
   input  wire logic        i_psel,               // apb select
   input  wire logic        i_penable,            // apb access phase
   input  wire logic        i_pwrite,             // apb write
   input  wire logic [11:0] i_paddr,              // apb byte address
   input  wire logic [31:0] i_pwdata,             // apb write data
   input  wire logic [3:0]  i_pstrb,              // apb byte strobes
   output logic      [31:0] o_prdata,             // apb read data
   output logic             o_pready,             // apb ready
   output logic             o_pslverr,            // apb error, unmapped
   input  wire logic        i_irq_pin_n,          // external pin, active low
   input  wire logic        i_vector_fetch,       // cpu fetching this vector
   input  wire logic        i_break_state,        // cpu in break state
   input  wire logic        i_break_clear_enable, // break clear allowed
   output logic             o_request,            // to priority logic
   output logic             o_pin_level,          // synced pin level
   output logic      [15:0] o_vector_addr,        // handler vector address
   output logic             o_irq                 // event interrupt level
);

   // address compare, used by every register decode
   function automatic logic addr_is(input eil_addr_t a,
                                    input eil_addr_t off);
      addr_is = (a == off);
   endfunction

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic       sync1_q;
   logic       sync2_q;
   logic       prev_q;
   logic [1:0] warm_q;
   logic       latch_q;
   logic       latch_d;
   logic       ackseen_q;
   logic       ackseen_d;
   logic       mask_q;
   logic       mask_d;
   eil_sens_e  sens_q;
   eil_sens_e  sens_d;
   eil_ev_t    evt_q;
   eil_ev_t    evt_d;
   eil_ev_t    een_q;
   eil_ev_t    een_d;
   eil_word_t  rdata_q;
   logic       ready_q;
   logic       slverr_q;
   logic       req_q;
   logic       pinlvl_q;
   logic       irq_q;
   logic [15:0] vec_q;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   wire        acc     = i_psel & i_penable;
   wire        dec_scr = addr_is(i_paddr, `EIL_OFF_SCR);
   wire        dec_evt = addr_is(i_paddr, `EIL_OFF_EVT);
   wire        dec_een = addr_is(i_paddr, `EIL_OFF_EEN);
   wire        dec_vec = addr_is(i_paddr, `EIL_OFF_VEC);
   wire        mapped  = dec_scr | dec_evt | dec_een | dec_vec;
   // one wait state: the write lands on the edge that sees pready high
   wire        wr_go   = acc & ready_q & i_pwrite & mapped & i_pstrb[0];
   wire        wr_scr  = wr_go & dec_scr;
   wire        wr_evt  = wr_go & dec_evt;
   wire        wr_een  = wr_go & dec_een;

   // ---------------------------------------------------------------
   // pin conditioning
   // ---------------------------------------------------------------
   // only the second stage is looked at; first stage is metastable risk
   wire        pin_high = sync2_q;
   wire        pin_low  = ~sync2_q;
   // history is only real once the chain holds pin samples, so a pin
   // held low across reset gives no edge until it goes high and low
   wire        armed    = (warm_q == `EIL_WARM_DONE);
   wire        fall     = armed & prev_q & ~sync2_q;
   wire        lvl_mode = (sens_q == EIL_SENS_LEVEL);

   // ---------------------------------------------------------------
   // acknowledge sources
   // ---------------------------------------------------------------
   // break protects the latch from software acknowledge unless the clear enable is set
   wire        brk_ok  = ~i_break_state | i_break_clear_enable;
   wire        sw_ack  = wr_scr & i_pwdata[`EIL_B_ACK] & brk_ok;
   wire        vec_ack = i_vector_fetch;
   wire        ack     = sw_ack | vec_ack;

   // ---------------------------------------------------------------
   // latch set and clear terms
   // ---------------------------------------------------------------
   // level mode keeps the request alive as long as the pin stays low
   wire        set_lat = fall | (lvl_mode & pin_low);
   // edge mode: any acknowledge clears at once
   wire        clr_edg = ~lvl_mode & ack;
   // level mode: acknowledge (now or earlier) plus pin back high
   wire        clr_lvl = lvl_mode & (ack | ackseen_q) & pin_high;
   wire        clr_lat = clr_edg | clr_lvl;

   // set beats clear so an edge during an acknowledge is not lost
   assign latch_d = set_lat | (latch_q & ~clr_lat);

   // remembers an acknowledge taken while the pin was still low
   assign ackseen_d = lvl_mode & latch_d & (ackseen_q | ack);

   // ---------------------------------------------------------------
   // control bits written by software
   // ---------------------------------------------------------------
   assign mask_d = wr_scr ? i_pwdata[`EIL_B_MASK] : mask_q;
   assign sens_d = wr_scr ? (i_pwdata[`EIL_B_MODE] ? EIL_SENS_LEVEL
                                                   : EIL_SENS_EDGE)
                          : sens_q;

   // ---------------------------------------------------------------
   // event status, write one to clear; enable, written directly
   // ---------------------------------------------------------------
   wire        ev_latch = set_lat & ~latch_q;
   wire        ev_ack   = clr_lat & latch_q & ~set_lat;
   wire [1:0]  ev_set   = {ev_ack, ev_latch};
   wire [1:0]  ev_w1c   = wr_evt ? i_pwdata[`EIL_EV_W-1:0] : `EIL_RST_EV;
   // hardware set wins over a same-cycle software clear
   assign evt_d = (evt_q & ~ev_w1c) | ev_set;
   assign een_d = wr_een ? i_pwdata[`EIL_EV_W-1:0] : een_q;

   // ---------------------------------------------------------------
   // read data mux
   // ---------------------------------------------------------------
   // acknowledge bit is never stored, so it reads zero
   wire [31:0] rd_scr = {28'h000_0000, latch_q, 1'b0, mask_q,
                         lvl_mode};
   wire [31:0] rd_evt = {30'h0000_0000, evt_q};
   wire [31:0] rd_een = {30'h0000_0000, een_q};
   wire [31:0] rd_vec = {`EIL_VEC_HI, `EIL_VEC_LO};
   wire [31:0] rd_val = dec_scr ? rd_scr :
                        dec_evt ? rd_evt :
                        dec_een ? rd_een :
                        dec_vec ? rd_vec : `EIL_RST_WORD;

   // ---------------------------------------------------------------
   // pin synchroniser and edge history
   // ---------------------------------------------------------------
   // reset to idle-high so releasing reset never fakes an edge
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         sync1_q <= `EIL_RST_PIN;
         sync2_q <= `EIL_RST_PIN;
         prev_q  <= `EIL_RST_PIN;
      end else begin
         sync1_q <= i_irq_pin_n;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // ---------------------------------------------------------------
   // warm-up count after reset for the edge detector
   // ---------------------------------------------------------------
   // saturates; costs three cycles of blindness to edges after reset
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         warm_q <= `EIL_RST_WARM;
      end else if (!armed) begin
         warm_q <= warm_q + `EIL_WARM_STEP;
      end
   end

   // ---------------------------------------------------------------
   // latch and level-mode acknowledge memory
   // ---------------------------------------------------------------
   // reset drops the request even while the pin is held low
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         latch_q   <= `EIL_RST_BIT;
         ackseen_q <= `EIL_RST_BIT;
      end else begin
         latch_q   <= latch_d;
         ackseen_q <= ackseen_d;
      end
   end

   // ---------------------------------------------------------------
   // mask and sensitivity
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         mask_q <= `EIL_RST_BIT;
         sens_q <= EIL_SENS_EDGE;
      end else begin
         mask_q <= mask_d;
         sens_q <= sens_d;
      end
   end

   // ---------------------------------------------------------------
   // event status and enable registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         evt_q <= `EIL_RST_EV;
         een_q <= `EIL_RST_EV;
      end else begin
         evt_q <= evt_d;
         een_q <= een_d;
      end
   end

   // ---------------------------------------------------------------
   // apb response: one wait state, then ready for one cycle
   // ---------------------------------------------------------------
   // fixed latency keeps the slave simple; costs one cycle per access
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ready_q  <= `EIL_RST_BIT;
         slverr_q <= `EIL_RST_BIT;
         rdata_q  <= `EIL_RST_WORD;
      end else begin
         ready_q  <= acc & ~ready_q;
         slverr_q <= acc & ~ready_q & ~mapped;
         rdata_q  <= (acc & ~ready_q & ~i_pwrite) ? rd_val
                                                  : `EIL_RST_WORD;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs toward the cpu
   // ---------------------------------------------------------------
   // request and irq follow next-state so they line up with the flags
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         req_q    <= `EIL_RST_BIT;
         pinlvl_q <= `EIL_RST_PIN;
         irq_q    <= `EIL_RST_BIT;
         vec_q    <= `EIL_VEC_HI;
      end else begin
         req_q    <= latch_d & ~mask_d;
         pinlvl_q <= sync2_q;
         irq_q    <= |(evt_d & een_d);
         vec_q    <= `EIL_VEC_HI;
      end
   end

   // ---------------------------------------------------------------
   // port assignments, all straight from flip-flops
   // ---------------------------------------------------------------
   assign o_prdata      = rdata_q;
   assign o_pready      = ready_q;
   assign o_pslverr     = slverr_q;
   assign o_request     = req_q;
   assign o_pin_level   = pinlvl_q;
   assign o_irq         = irq_q;
   assign o_vector_addr = vec_q;

endmodule
`default_nettype wire

// ===== verif/eil_pin_model.sv
// behavioural external device driving the active-low interrupt pin
`timescale 1ns/1ns
`default_nettype none
module eil_pin_model (
   input  wire logic i_clock, // bus clock
   input  wire logic i_level, // wanted pin level
   input  wire logic i_slow,  // add one cycle of lag
   output var  logic o_pin_n  // interrupt pin, active low
);
   logic hold_q = 1'b1;
   // pin idles high; changes only just after an edge, prompt or late
   initial o_pin_n = 1'b1;
   always @(posedge i_clock) begin
      hold_q <= i_level;
      o_pin_n <= i_slow ? hold_q : i_level;
   end
endmodule
`default_nettype wire

// ===== verif/eil_top_sva.sv
// concurrent checks on the external interrupt latch ports
`timescale 1ns/1ns
`default_nettype none
`include "eil_params.svh"
module eil_top_sva (
   input wire logic        i_clock,        // bus clock
   input wire logic        i_nrst,         // sync reset, active low
   input wire logic        i_psel,         // apb select
   input wire logic        i_penable,      // apb access
   input wire logic        i_pwrite,       // apb write
   input wire logic [11:0] i_paddr,        // apb address
   input wire logic        i_irq_pin_n,    // pin, active low
   input wire logic        i_vector_fetch, // vector fetch
   input wire logic [31:0] o_prdata,       // read data
   input wire logic        o_pready,       // ready
   input wire logic        o_pslverr,      // error
   input wire logic        o_request,      // request out
   input wire logic        o_pin_level,    // synced pin
   input wire logic [15:0] o_vector_addr,  // vector address
   input wire logic        o_irq           // event interrupt
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   logic [1:0] warm_q;
   wire        scr_rd = o_pready && !i_pwrite && i_paddr == `EIL_OFF_SCR;
   wire        mapped = i_paddr[1:0] == 2'h0 && i_paddr <= `EIL_OFF_VEC;
   wire        pin_hi = i_irq_pin_n && o_pin_level;
   // $past is only trusted once the sync chain has left reset
   always_ff @(posedge i_clock) begin
      if (!i_nrst) warm_q <= 2'h0;
      else if (warm_q != 2'h3) warm_q <= warm_q + 2'h1;
   end
   sequence s_setup; i_psel && !i_penable; endsequence
   sequence s_access; i_psel && i_penable; endsequence
   property p_answer; s_setup ##1 s_access |=> o_pready; endproperty
   a_answer: assert property (p_answer) else $error("late apb answer");
   property p_pulse; o_pready |=> !o_pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_unmapped; o_pready && !mapped |-> o_pslverr && o_prdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
   property p_ack_zero; scr_rd |-> o_prdata[31:4] == '0 && !o_prdata[2];
   endproperty
   a_ack_zero: assert property (p_ack_zero) else $error("ack bit read");
   property p_pend; scr_rd && $past(o_request) |-> o_prdata[`EIL_B_PEND];
   endproperty
   a_pend: assert property (p_pend) else $error("flag lost");
   property p_level; warm_q == 2'h3 |-> o_pin_level == $past(i_irq_pin_n, 3);
   endproperty
   a_level: assert property (p_level) else $error("pin level wrong");
   property p_fetch; i_vector_fetch && pin_hi && $past(i_irq_pin_n) &&
      $past(i_irq_pin_n, 2) && warm_q == 2'h3 |=> !o_request; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch kept latch");
   property p_reset; disable iff (1'b0) !i_nrst |=> !o_request && !o_irq &&
      !o_pready && o_pin_level; endproperty
   a_reset: assert property (p_reset) else $error("reset value wrong");
   property p_vec; o_vector_addr == `EIL_VEC_HI; endproperty
   a_vec: assert property (p_vec) else $error("vector address wrong");
endmodule
bind eil_top eil_top_sva i_eil_top_sva (.i_clock(i_clock), .i_nrst(i_nrst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_irq_pin_n(i_irq_pin_n),
   .i_vector_fetch(i_vector_fetch), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_request(o_request),
   .o_pin_level(o_pin_level), .o_vector_addr(o_vector_addr), .o_irq(o_irq));
`default_nettype wire

// ===== verif/eil_top_test.sv
// self-checking bench for the external interrupt latch
`timescale 1ns/1ns
`default_nettype none
`include "eil_params.svh"
module eil_top_test import eil_pkg::*;;
   logic        i_clock = 1'b0, i_nrst = 1'b0, i_psel = 1'b0;
   logic        i_penable = 1'b0, i_pwrite = 1'b0, i_vector_fetch = 1'b0;
   logic        i_break_state = 1'b0, i_break_clear_enable = 1'b0;
   eil_addr_t   i_paddr = 12'h000;
   eil_word_t   i_pwdata = 32'h0000_0000, o_prdata, rd;
   logic [3:0]  i_pstrb = 4'hf, strb = 4'hf;
   logic        o_pready, o_pslverr, o_request, o_pin_level, o_irq, err;
   logic [15:0] o_vector_addr;
   logic        i_irq_pin_n, pin_req = 1'b1, pin_slow = 1'b0;
   logic [31:0] rnd = 32'hd038;
   int          fails = 0, checks_done = 0, cycles = 0;
   bit          m_mode, m_mask, m_pend, m_ack; // reference model
   eil_top i_eil_top (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_irq_pin_n(i_irq_pin_n),
      .i_vector_fetch(i_vector_fetch), .i_break_state(i_break_state),
      .i_break_clear_enable(i_break_clear_enable), .o_request(o_request),
      .o_pin_level(o_pin_level), .o_vector_addr(o_vector_addr), .o_irq(o_irq));
   eil_pin_model i_eil_pin_model (.i_clock(i_clock), .i_level(pin_req),
      .i_slow(pin_slow), .o_pin_n(i_irq_pin_n));
   // clock and hang guard
   initial begin
      forever #50 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         close_out();
      end
   end
   task automatic close_out;
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input eil_word_t seen, input eil_word_t exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // apb master: request held until pready is sampled high
   task automatic apb(input logic wr, input eil_addr_t a, input eil_word_t d);
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      i_pstrb <= strb;
      @(posedge i_clock);
      i_penable <= 1'b1;
      do @(posedge i_clock); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic state;
      apb(1'b0, `EIL_OFF_SCR, 32'h0000_0000);
      chk(rd, {28'h0, m_pend, 1'b0, m_mask, m_mode});
      chk(32'(o_request), 32'(m_pend & !m_mask));
   endtask
   // v is {ack, mask, mode}; ack blocked in break unless enabled
   task automatic wscr(input logic [2:0] v);
      apb(1'b1, `EIL_OFF_SCR, {29'h0, v});
      if (strb[0]) begin
         m_mask = v[1];
         // the acknowledge acts under the mode in force before the write
         if (v[2] && !(i_break_state && !i_break_clear_enable)) begin
            if (!m_mode || pin_req) m_pend = 0;
            else m_ack = 1;
         end
         if (!v[0]) m_ack = 0;
         m_mode = v[0];
         if (m_mode && !pin_req) m_pend = 1;
      end
   endtask
   // pin change, alternating prompt and late device
   task automatic pin(input logic v);
      pin_req <= v;
      pin_slow <= ~pin_slow;
      repeat (7) @(posedge i_clock);
      chk(32'(o_pin_level), 32'(v));
      if (!v) m_pend = 1;
      else if (m_mode && m_ack) m_pend = 0;
      if (v) m_ack = 0;
   endtask
   task automatic fetch;
      @(posedge i_clock);
      i_vector_fetch <= 1'b1;
      @(posedge i_clock);
      i_vector_fetch <= 1'b0;
      if (!m_mode || pin_req) m_pend = 0;
      else m_ack = 1;
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge i_clock);
      i_nrst <= 1'b1;
      state();
      apb(1'b0, `EIL_OFF_VEC, 32'h0000_0000);
      chk(rd, {`EIL_VEC_HI, `EIL_VEC_LO});
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      pin(0); state();
      pin(1); state();
      wscr(3'b100); state();
      wscr(3'b010); pin(0); state();
      wscr(3'b000); state();
      fetch(); state();
      pin(1); wscr(3'b100); pin(0); state();
      wscr(3'b101); pin(1); state();
      pin(0); wscr(3'b011); state();
      wscr(3'b101); state();
      pin(1); state();
      pin(0); pin(1); state();
      fetch(); state();
      wscr(3'b000); pin(0); pin(1);
      i_break_state <= 1'b1;
      wscr(3'b100); state();
      i_break_clear_enable <= 1'b1;
      wscr(3'b100); i_break_state <= 1'b0; state();
      i_break_clear_enable <= 1'b0;
      apb(1'b1, `EIL_OFF_EVT, 32'h0000_0003);
      apb(1'b1, `EIL_OFF_EEN, 32'h0000_0001);
      apb(1'b0, `EIL_OFF_EEN, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      pin(0); chk(32'(o_irq), 32'h0000_0001);
      apb(1'b1, `EIL_OFF_EEN, 32'h0000_0000); state();
      chk(32'(o_irq), 32'h0000_0000);
      apb(1'b1, `EIL_OFF_EEN, 32'h0000_0001);
      apb(1'b1, `EIL_OFF_EVT, 32'h0000_0001); state();
      chk(32'(o_irq), 32'h0000_0000);
      // reset with the pin still low must drop the request
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_nrst <= 1'b1;
      {m_mode, m_mask, m_pend, m_ack} = 4'h0;
      state(); pin(1); state();
      // random strobes and field values; bit0 strobe gates the write
      repeat (8) begin
         rnd = lfsr(rnd);
         strb = rnd[7:4];
         wscr({1'b0, rnd[1:0]}); state();
      end
      close_out();
   end
endmodule
`default_nettype wire
